//--- dv/flash_status_and_array_guard_tb.sv
`timescale 1ns/100ps
module flash_status_and_array_guard_tb;
    // ----
    // Clock, reset and hookup.
    // ----
    logic clk_i, rst_n_i, ce, guard_n_i, lclk, cs_n, si, so, so_oe, pg, eg, rj;
    logic [15:0] status_o, exp_st;
    logic [1:0] kind;
    logic [23:0] op_addr;
    logic [2:0] seen = 3'h0;
    logic [31:0] rnd_q = 32'haca0;
    int num_errors = 0;
    int check_count = 0;
    flash_status_and_array_guard #(.CONFIG_CYCLES(30), .PAGE_CYCLES(40), .WIPE_CYCLES(60))
    i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .link_clk_i(lclk), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_o(so_oe), .guard_n_i(guard_n_i), .status_o(status_o),
        .prog_go_o(pg), .erase_go_o(eg), .erase_kind_o(kind), .op_addr_o(op_addr),
        .reject_o(rj));
    spi_host_model i_host (.link_clk_o(lclk), .cs_n_o(cs_n), .si_o(si), .so_i(so),
        .so_oe_i(so_oe));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // One-cycle pulses are caught mid-cycle and held until the next command.
    always @(negedge clk_i) seen = seen | {pg, eg, rj};
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // Whether an address is guarded, from the guard bits and the invert bit.
    function automatic logic guarded(input logic [4:0] bp, input logic inv, input logic [20:0] a);
        logic [20:0] sz;
        logic hit;
        sz = bp[4] ? (21'h001000 << (bp[2] ? 3 : int'(bp[1:0]) - 1))
            : (21'h010000 << (int'(bp[2:0]) - 1));
        if (bp[2:0] == 3'h0) hit = 1'b0;
        else if (bp[2:1] == 2'h3) hit = 1'b1;
        else hit = bp[3] ? (a < sz) : (a >= 21'h000000 - sz);
        return hit ^ inv;
    endfunction
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (exp !== got) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [47:0] bits, input int nbytes);
        logic [7:0] rd;
        #1 seen = 3'h0;
        i_host.frame(bits, nbytes, rd);
        repeat (10) @(negedge clk_i);
    endtask
    task automatic wait_idle();
        int n = 0;
        while (status_o[0] !== 1'b0 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        check("busy end", 24'h0, 24'(status_o[0]));
    endtask
    // Status write; a refused one leaves the permit set, so it is cleared again.
    task automatic wr_status(input logic [15:0] w);
        logic ok;
        ok = !(exp_st[7] && !guard_n_i && !exp_st[9]);
        cmd(48'h06, 1);
        cmd({24'h0, 8'h01, w[7:0], w[15:8]}, 3);
        check("wr events", 24'(!ok), 24'(seen));
        if (ok) begin
            check("busy on", 24'h1, 24'(status_o[0]));
            exp_st = (w & 16'h46fc) | (exp_st & 16'h0400);
            wait_idle();
        end else begin
            cmd(48'h04, 1);
        end
        check("status", 24'(exp_st), 24'(status_o));
    endtask
    task automatic read_back();
        logic [7:0] lo, hi;
        i_host.frame(48'h0500, 2, lo);
        repeat (6) @(negedge clk_i);
        i_host.frame(48'h3500, 2, hi);
        repeat (6) @(negedge clk_i);
        check("read word", 24'(exp_st), {8'h0, hi, lo});
    endtask
    // Program or sector wipe at a, judged against the guarded area.
    task automatic array_op(input logic [20:0] a, input logic wipe);
        logic hit;
        hit = guarded(exp_st[6:2], exp_st[14], wipe ? {a[20:12], 12'h000} : a);
        cmd(48'h06, 1);
        if (wipe) cmd({16'h0, 8'h20, 3'h0, a}, 4);
        else cmd({8'h0, 8'h02, 3'h0, a, 8'h5a}, 5);
        check("op events", {21'h0, !wipe && !hit, wipe && !hit, hit}, 24'(seen));
        if (!hit) begin
            check("op addr", wipe ? {3'h0, a[20:12], 12'h0} : {3'h0, a}, op_addr);
            if (wipe) begin
                check("erase kind", 24'(flash_guard_pkg::WIPE_SECTOR), 24'(kind));
            end
            check("permit clr", 24'h0, 24'(status_o[1]));
            wait_idle();
        end else begin
            cmd(48'h04, 1);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs roughly 10,000 cycles.
    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
    // ----
    // Main sequence.
    // ----
    initial begin
        logic [20:0] b;
        rst_n_i = 1'b0;
        ce = 1'b1;
        guard_n_i = 1'b1;
        exp_st = 16'h0000;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check("reset", 24'h0, 24'(status_o));
        cmd(48'h01_1c00, 3);
        check("no permit wr", 24'h1, 24'(seen));
        cmd(48'h02_000000_5a, 5);
        check("no permit pg", 24'h1, 24'(seen));
        for (int k = 0; k < 64; k++) begin
            rnd_q = xorshift(rnd_q);
            guard_n_i = rnd_q[31];
            wr_status({rnd_q[15], k[5], rnd_q[13:11], 2'b00, rnd_q[8], 1'b0, k[4:0],
                rnd_q[1:0]});
            read_back();
            b = 21'h1 << (12 + rnd_q[19:16] % 9);
            b = rnd_q[20] ? b : b - 21'h1;
            b = rnd_q[21] ? b : ~b;
            array_op(rnd_q[22] ? rnd_q[30:10] : b, rnd_q[23]);
        end
        for (int k = 0; k < 4; k++) begin
            wr_status(k[1] ? (k[0] ? 16'h4000 : 16'h401c) : (k[0] ? 16'h0004 : 16'h0000));
            cmd(48'h06, 1);
            cmd(k[1] ? 48'hc7 : 48'h60, 1);
            check("chip wipe", {21'h0, 1'b0, !k[0], k[0]}, 24'(seen));
            if (!k[0]) begin
                check("chip kind", 24'(flash_guard_pkg::WIPE_CHIP), 24'(kind));
            end
            if (k[0]) cmd(48'h04, 1);
            else wait_idle();
        end
        guard_n_i = 1'b1;
        wr_status(16'h0080);
        guard_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        wr_status(16'h0094);
        guard_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        wr_status(16'h0280);
        guard_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        wr_status(16'h0294);
        wr_status(16'h0400);
        wr_status(16'h0000);
        read_back();
        cmd(48'hb9, 1);
        cmd(48'h06, 1);
        check("asleep", 24'h0, 24'(status_o[1]));
        cmd(48'h60, 1);
        check("asleep ignore", 24'h0, 24'(seen));
        cmd(48'hab, 1);
        cmd(48'h06, 1);
        check("awake", 24'h1, 24'(status_o[1]));
        cmd(48'h60, 1);
        // A frozen clock enable must stall the erase timer well past its length.
        ce = 1'b0;
        repeat (80) @(negedge clk_i);
        check("frozen busy", 24'h1, 24'(status_o[0]));
        ce = 1'b1;
        cmd(48'h75, 1);
        check("suspended", 24'h8000, 24'(status_o & 16'h8001));
        cmd(48'h7a, 1);
        check("resumed", 24'h0001, 24'(status_o & 16'h8001));
        cmd(48'h75, 1);
        rst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("power cycle", 24'h0, 24'(status_o));
        report_and_stop();
    end
endmodule

//--- dv/spi_host_model.sv
`timescale 1ns/100ps
// ----
// Host side of the serial link, mode 0, clock parked low outside frames.
// ----
module spi_host_model (
    // Serial link toward the device.
    output logic link_clk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    // Idle levels; the data line keeps toggling so a stale bit is never seen.
    initial begin
        link_clk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    always #11 if (cs_n_o) si_o = ~si_o;
    // Sends nbytes MSB first and returns the last byte sampled from the data out line.
    task automatic frame(input logic [47:0] bits, input int nbytes, output logic [7:0] rd);
        cs_n_o = 1'b0;
        #10;
        for (int i = nbytes * 8 - 1; i >= 0; i--) begin
            si_o = bits[i];
            #7.5 link_clk_o = 1'b1;
            rd = {rd[6:0], so_i & so_oe_i};
            #7.5 link_clk_o = 1'b0;
        end
        #10 cs_n_o = 1'b1;
    endtask
endmodule

//--- rtl/flash_guard_pkg.sv
package flash_guard_pkg;

    // -------------------------------------------------------------------
    // Status word field positions.
    // -------------------------------------------------------------------
    localparam int BUSY_POS = 0;
    localparam int PERMIT_POS = 1;
    localparam int GUARD_LO_POS = 2;
    localparam int LOCK_SEL_POS = 7;
    localparam int LANE_POS = 9;
    localparam int SEAL_POS = 10;
    localparam int INVERT_POS = 14;
    localparam int SUSPEND_POS = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // -------------------------------------------------------------------
    // Command codes.
    // -------------------------------------------------------------------
    localparam logic [7:0] OP_PERMIT_SET = 8'h06;
    localparam logic [7:0] OP_PERMIT_CLR = 8'h04;
    localparam logic [7:0] OP_READ_LOW = 8'h05;
    localparam logic [7:0] OP_READ_HIGH = 8'h35;
    localparam logic [7:0] OP_CONFIG_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_WIPE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_WIPE = 8'hd8;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;

    // -------------------------------------------------------------------
    // Array geometry and wipe kinds.
    // -------------------------------------------------------------------
    localparam logic [21:0] ARRAY_BYTES = 22'h200000;
    localparam logic [21:0] SMALL_UNIT = 22'h001000;
    localparam logic [21:0] LARGE_UNIT = 22'h010000;
    localparam logic [23:0] SECTOR_MASK = 24'h000fff;
    localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
    localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
    localparam logic [1:0] WIPE_SECTOR = 2'h0;
    localparam logic [1:0] WIPE_BLOCK32 = 2'h1;
    localparam logic [1:0] WIPE_BLOCK64 = 2'h2;
    localparam logic [1:0] WIPE_CHIP = 2'h3;

    // -------------------------------------------------------------------
    // Operation durations in clk_i cycles.
    // -------------------------------------------------------------------
    localparam int CONFIG_CYCLES = 16;
    localparam int PAGE_CYCLES = 32;
    localparam int WIPE_CYCLES = 64;

endpackage

//--- rtl/flash_status_and_array_guard.sv
`timescale 1ns/100ps
module flash_status_and_array_guard #(
    parameter int CONFIG_CYCLES = flash_guard_pkg::CONFIG_CYCLES,
    parameter int PAGE_CYCLES = flash_guard_pkg::PAGE_CYCLES,
    parameter int WIPE_CYCLES = flash_guard_pkg::WIPE_CYCLES
) (
    // System clock, reset and freeze.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Serial link.
    input wire logic link_clk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    // Write-guard pin.
    input wire logic guard_n_i,
    // Status and array operation requests.
    output logic [15:0] status_o,
    output logic prog_go_o,
    output logic erase_go_o,
    output logic [1:0] erase_kind_o,
    output logic [23:0] op_addr_o,
    output logic reject_o
);

    // -------------------------------------------------------------------
    // Link side: shifts command frames in on the rising link clock.
    // -------------------------------------------------------------------
    logic frame_rst_n;
    logic [2:0] bit_q, byte_q;
    logic [7:0] sh_q;
    logic [7:0] rec_op_q;
    logic [23:0] rec_addr_q;
    logic [7:0] rec_d0_q, rec_d1_q;
    logic [2:0] rec_bits_q, rec_bytes_q;
    logic [7:0] rd_byte_q;
    logic [15:0] snap_q;
    logic [7:0] in_byte;
    logic byte_done;
    logic [2:0] byte_nx;

    // The bit and byte counters restart with each frame; the record survives it.
    assign frame_rst_n = rst_n_i & ~cs_n_i;
    assign in_byte = {sh_q[6:0], si_i};
    assign byte_done = (bit_q == 3'h7);
    assign byte_nx = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;

    // Frame position counters.
    always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (byte_done) begin
                byte_q <= byte_nx;
            end
        end
    end

    // Command record, stable once the link clock stops at frame end.
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_q <= 8'h00;
            rec_op_q <= 8'h00;
            rec_addr_q <= 24'h000000;
            rec_d0_q <= 8'h00;
            rec_d1_q <= 8'h00;
            rec_bits_q <= 3'h0;
            rec_bytes_q <= 3'h0;
            rd_byte_q <= 8'h00;
        end else begin
            sh_q <= in_byte;
            rec_bits_q <= bit_q + 3'h1;
            rec_bytes_q <= byte_done ? byte_nx : byte_q;
            if (byte_done) begin
                case (byte_q)
                    3'h0: rec_op_q <= in_byte;
                    3'h1: rec_addr_q[23:16] <= in_byte;
                    3'h2: rec_addr_q[15:8] <= in_byte;
                    3'h3: rec_addr_q[7:0] <= in_byte;
                    default: ;
                endcase
                if (byte_q == 3'h1) begin
                    rec_d0_q <= in_byte;
                end
                if (byte_q == 3'h2) begin
                    rec_d1_q <= in_byte;
                end
                // Status read loads the selected half once, after the opcode byte.
                if (byte_q == 3'h0) begin
                    rd_byte_q <= (in_byte == flash_guard_pkg::OP_READ_HIGH) ?
                        snap_q[15:8] : snap_q[7:0];
                end
            end
        end
    end

    // Status bits shift out on the falling link clock, MSB first.
    logic rd_active;
    assign rd_active = (byte_q != 3'h0) && ((rec_op_q == flash_guard_pkg::OP_READ_LOW) ||
        (rec_op_q == flash_guard_pkg::OP_READ_HIGH));
    always_ff @(negedge link_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_o <= rd_byte_q[3'h7 - bit_q];
            so_oe_o <= rd_active;
        end
    end

    // -------------------------------------------------------------------
    // Crossing into the system clock.
    // -------------------------------------------------------------------
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic guard_s1_q, guard_s2_q;
    logic frame_end;

    // Chip select and guard pin pass two flip-flops before use.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            guard_s1_q <= 1'b1;
            guard_s2_q <= 1'b1;
        end else if (ce_i) begin
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            guard_s1_q <= guard_n_i;
            guard_s2_q <= guard_s1_q;
        end
    end
    assign frame_end = cs_s2_q & ~cs_s3_q;

    // -------------------------------------------------------------------
    // Status fields and protection decode.
    // -------------------------------------------------------------------
    logic permit_q, lock_sel_q, lane_q, seal_q, invert_q, suspend_q, sleep_q, cfg_go_q;
    logic [4:0] guard_q;
    logic [15:0] cnt_q;
    logic busy;
    logic hw_lock;
    logic [15:0] word;

    // Guarded-area test: base region then optional complement.
    function automatic logic area_hit(input logic [23:0] a, input logic [4:0] g,
                                      input logic inv);
        logic [2:0] n;
        logic [21:0] size;
        logic [21:0] off;
        logic hit;
        n = g[4] ? (g[2] ? 3'h3 : {1'b0, g[1:0] - 2'h1}) : (g[2:0] - 3'h1);
        size = (g[4] ? flash_guard_pkg::SMALL_UNIT : flash_guard_pkg::LARGE_UNIT) << n;
        off = {1'b0, a[20:0]};
        hit = g[3] ? (off < size) : (off >= (flash_guard_pkg::ARRAY_BYTES - size));
        if (g[2:0] == 3'h0) begin
            hit = 1'b0;
        end else if (g[2:1] == 2'h3) begin
            hit = 1'b1;
        end
        area_hit = hit ^ inv;
    endfunction

    // Busy while counting and not suspended; guard pin counts only as guard input.
    assign busy = (cnt_q != 16'h0000) & ~suspend_q;
    assign hw_lock = lock_sel_q & ~guard_s2_q & ~lane_q;
    assign word = {suspend_q, invert_q, 3'h0, seal_q, lane_q, 1'b0, lock_sel_q,
        guard_q, permit_q, busy};

    // -------------------------------------------------------------------
    // Command decode at frame end.
    // -------------------------------------------------------------------
    logic aligned;
    logic [7:0] op;
    logic awake;
    logic idle;
    logic is_cfg;
    logic is_page;
    logic is_wipe;
    logic is_chip;
    logic [1:0] wipe_kind;
    logic [23:0] wipe_mask;
    logic [23:0] wipe_base;
    logic wipe_ok;
    logic chip_ok;
    logic cfg_ok;
    logic page_ok;

    assign aligned = (rec_bits_q == 3'h0);
    assign op = rec_op_q;
    assign awake = frame_end & aligned & ~sleep_q;
    assign idle = ~busy & ~suspend_q;
    assign is_cfg = awake & idle & (op == flash_guard_pkg::OP_CONFIG_WRITE) &
        (rec_bytes_q >= 3'h2);
    assign is_page = awake & idle & (op == flash_guard_pkg::OP_PAGE_WRITE) &
        (rec_bytes_q >= 3'h5);
    assign is_wipe = awake & idle & (rec_bytes_q == 3'h4) &
        ((op == flash_guard_pkg::OP_SECTOR_WIPE) || (op == flash_guard_pkg::OP_BLOCK32_WIPE) ||
        (op == flash_guard_pkg::OP_BLOCK64_WIPE));
    assign is_chip = awake & idle & (rec_bytes_q == 3'h1) &
        ((op == flash_guard_pkg::OP_CHIP_WIPE_A) || (op == flash_guard_pkg::OP_CHIP_WIPE_B));
    assign wipe_kind = (op == flash_guard_pkg::OP_SECTOR_WIPE) ? flash_guard_pkg::WIPE_SECTOR :
        (op == flash_guard_pkg::OP_BLOCK32_WIPE) ? flash_guard_pkg::WIPE_BLOCK32 :
        flash_guard_pkg::WIPE_BLOCK64;
    assign wipe_mask = (op == flash_guard_pkg::OP_SECTOR_WIPE) ? flash_guard_pkg::SECTOR_MASK :
        (op == flash_guard_pkg::OP_BLOCK32_WIPE) ? flash_guard_pkg::BLOCK32_MASK :
        flash_guard_pkg::BLOCK64_MASK;
    assign wipe_base = rec_addr_q & ~wipe_mask;
    assign cfg_ok = permit_q & ~hw_lock;
    assign page_ok = permit_q & ~area_hit(rec_addr_q, guard_q, invert_q);
    assign wipe_ok = permit_q & ~area_hit(wipe_base, guard_q, invert_q) &
        ~area_hit(wipe_base | wipe_mask, guard_q, invert_q);
    assign chip_ok = permit_q & (({guard_q[2:0], invert_q} == 4'h0) ||
        ({guard_q[2:0], invert_q} == 4'hf));

    // Permit latch, power state and suspend flag.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            permit_q <= 1'b0;
            sleep_q <= 1'b0;
            suspend_q <= 1'b0;
        end else if (ce_i) begin
            if (awake & idle & (op == flash_guard_pkg::OP_PERMIT_SET) & (rec_bytes_q == 3'h1)) begin
                permit_q <= 1'b1;
            end else if ((awake & (op == flash_guard_pkg::OP_PERMIT_CLR)) |
                         (is_cfg & cfg_ok) | (is_page & page_ok) | (is_wipe & wipe_ok) |
                         (is_chip & chip_ok)) begin
                permit_q <= 1'b0;
            end
            if (frame_end & (op == flash_guard_pkg::OP_WAKE)) begin
                sleep_q <= 1'b0;
            end else if (awake & idle & (op == flash_guard_pkg::OP_SLEEP)) begin
                sleep_q <= 1'b1;
            end
            if (awake & busy & (op == flash_guard_pkg::OP_SUSPEND)) begin
                suspend_q <= 1'b1;
            end else if (awake & (op == flash_guard_pkg::OP_RESUME)) begin
                suspend_q <= 1'b0;
            end
        end
    end

    // Configuration fields: only the status write changes them.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_q <= flash_guard_pkg::STATUS_RESET[6:2];
            lock_sel_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::LOCK_SEL_POS];
            lane_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::LANE_POS];
            seal_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::SEAL_POS];
            invert_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::INVERT_POS];
        end else if (ce_i && is_cfg && cfg_ok) begin
            guard_q <= rec_d0_q[6:2];
            lock_sel_q <= rec_d0_q[7];
            if (rec_bytes_q >= 3'h3) begin
                lane_q <= rec_d1_q[1];
                seal_q <= seal_q | rec_d1_q[2];
                invert_q <= rec_d1_q[6];
            end
        end
    end

    // Operation timer, request pulses and status snapshot.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
            cfg_go_q <= 1'b0;
            prog_go_o <= 1'b0;
            erase_go_o <= 1'b0;
            erase_kind_o <= flash_guard_pkg::WIPE_SECTOR;
            op_addr_o <= 24'h000000;
            reject_o <= 1'b0;
            status_o <= flash_guard_pkg::STATUS_RESET;
            snap_q <= flash_guard_pkg::STATUS_RESET;
        end else if (ce_i) begin
            cfg_go_q <= is_cfg & cfg_ok;
            prog_go_o <= is_page & page_ok;
            erase_go_o <= (is_wipe & wipe_ok) | (is_chip & chip_ok);
            reject_o <= (is_cfg & ~cfg_ok) | (is_page & ~page_ok) | (is_wipe & ~wipe_ok) |
                (is_chip & ~chip_ok);
            if (is_cfg & cfg_ok) begin
                cnt_q <= 16'(CONFIG_CYCLES);
            end else if (is_page & page_ok) begin
                cnt_q <= 16'(PAGE_CYCLES);
                op_addr_o <= rec_addr_q;
            end else if ((is_wipe & wipe_ok) | (is_chip & chip_ok)) begin
                cnt_q <= 16'(WIPE_CYCLES);
                op_addr_o <= is_chip ? 24'h000000 : wipe_base;
                erase_kind_o <= is_chip ? flash_guard_pkg::WIPE_CHIP : wipe_kind;
            end else if (busy) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            status_o <= word;
            if (cs_s2_q) begin
                snap_q <= word;
            end
        end
    end

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    default clocking chk_cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_prog_needs_permit: assert property ($rose(prog_go_o) |-> $past(permit_q))
        else $error("Program started without permit.");
    chk_prog_clears_permit: assert property ($rose(prog_go_o) |-> !permit_q)
        else $error("Permit still set after program start.");
    chk_prog_outside_area: assert property ($rose(prog_go_o) |->
        !area_hit(op_addr_o, guard_q, invert_q))
        else $error("Program started inside guarded area.");
    chk_chip_wipe_gate: assert property ($rose(erase_go_o) &&
        erase_kind_o == flash_guard_pkg::WIPE_CHIP |->
        (guard_q[2:0] == {3{invert_q}}))
        else $error("Full wipe with mixed guard bits.");
    chk_lock_blocks_write: assert property ($rose(cfg_go_q) |->
        !$past(hw_lock) && $past(permit_q))
        else $error("Status write under hardware lock.");
    chk_seal_sticky: assert property ($past(seal_q) |-> seal_q)
        else $error("Seal cleared.");
    chk_busy_follows_go: assert property ($rose(prog_go_o) |-> ##1 status_o[0])
        else $error("Busy flag not raised after program start.");
    chk_sleep_ignores: assert property ($past(sleep_q) && $past(ce_i) |->
        !$rose(prog_go_o) && !$rose(erase_go_o) && !$rose(cfg_go_q))
        else $error("Command obeyed in deep power-down.");
    chk_suspend_cause: assert property ($rose(suspend_q) |->
        $past(frame_end) && $past(op) == flash_guard_pkg::OP_SUSPEND)
        else $error("Suspend flag set without suspend command.");

    cov_prog: cover property ($rose(prog_go_o));
    cov_chip_wipe: cover property ($rose(erase_go_o) &&
        erase_kind_o == flash_guard_pkg::WIPE_CHIP);
    cov_cfg_write: cover property ($rose(cfg_go_q));
    cov_suspend: cover property ($rose(suspend_q));

endmodule
